// file: src/byte_io_port_latch.sv
// eight-bit bus port latch with two selects and a service request
// assumes inputs other than rst_b and clear_b synchronous to clk; strobe and selects are sampled
`timescale 1ns/1ps
module byte_io_port_latch
  import byte_io_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear_b,
  input wire logic modeSelect,
  input wire logic strobe,
  input wire logic selectFirst,
  input wire logic selectSecond,
  input wire logic [WIDTH-1:0] data_in_bus,
  output logic [WIDTH-1:0] data_out_bus,
  output logic dataOutEnable,
  output logic service_request,
  output logic captureValid,
  output logic [WIDTH-1:0] captureData,
  input wire logic captureReady,
  output logic captureRoom
);

  initial begin
    if (WIDTH != DATA_W || DEPTH < 2) begin
      $error("byte_io_port_latch needs WIDTH of DATA_W and DEPTH >= 2");
    end
  end

  logic rstSync_b, clrSync_b, regRst_b, clrInput_b;

  assign clrInput_b = rst_b && clear_b;

  reset_release_sync u_rst_sync (
    .clk(clk),
    .async_b(rst_b),
    .sync_b(rstSync_b)
  );

  reset_release_sync u_clr_sync (
    .clk(clk),
    .async_b(clrInput_b),
    .sync_b(clrSync_b)
  );

  assign regRst_b = clrSync_b;

  // mode is caught once after reset release, then frozen
  port_mode_t mode_q, mode_d;
  logic modeLock_q, modeLock_d;

  always_comb begin
    modeLock_d = 1'b1;
    if (modeLock_q) begin
      mode_d = mode_q;
    end else begin
      mode_d = port_mode_t'(modeSelect);
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      mode_q <= MODE_INPUT;
      modeLock_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      modeLock_q <= modeLock_d;
    end
  end

  function automatic logic selected(port_mode_t m, logic s1, logic s2);
    if (m == MODE_OUTPUT) begin
      return !s1 && s2;
    end else begin
      return s1 && s2;
    end
  endfunction

  // edge detection state
  logic strobePrev_q, strobePrev_d;
  logic selPrev_q, selPrev_d;
  logic loadPrev_q, loadPrev_d;
  logic sel, load, strobeFall, selFall;

  assign sel = selected(mode_q, selectFirst, selectSecond);

  // output-mode write needs selectFirst low and selectSecond high
  // no load before the mode is known, the decode would be wrong
  assign load = modeLock_q && strobe && (mode_q == MODE_INPUT || sel);

  assign strobeFall = strobePrev_q && !strobe;
  assign selFall = selPrev_q && !sel;

  always_comb begin
    strobePrev_d = strobe;
    selPrev_d = sel;
    loadPrev_d = load;
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      strobePrev_q <= 1'b0;
      selPrev_q <= 1'b0;
      loadPrev_q <= 1'b0;
    end else begin
      strobePrev_q <= strobePrev_d;
      selPrev_q <= selPrev_d;
      loadPrev_q <= loadPrev_d;
    end
  end

  // buffer and request flag
  logic [WIDTH-1:0] latch_q, latch_d;
  logic srActive_q, srActive_d;
  logic srSet, srClr;

  always_comb begin
    latch_d = latch_q;
    if (load) begin
      latch_d = data_in_bus;
    end
    if (mode_q == MODE_INPUT) begin
      srSet = strobeFall && !sel;
      srClr = selFall;
    end else begin
      srSet = selFall;
      srClr = strobeFall;
    end
    // set wins over clear in the same cycle
    srActive_d = srSet || (srActive_q && !srClr);
  end

  always_ff @(posedge clk or negedge regRst_b) begin
    if (!regRst_b) begin
      latch_q <= LATCH_RST;
      srActive_q <= SR_ACTIVE_RST;
    end else begin
      latch_q <= latch_d;
      srActive_q <= srActive_d;
    end
  end

  // drivers and pin sit outside the clear so an output port keeps
  // driving; the pin shows a clear one edge late, at the mode's idle
  logic outEn_q, outEn_d;
  logic srPin_q, srPin_d;
  logic srShown;

  always_comb begin
    outEn_d = (mode_q == MODE_OUTPUT) || sel;
    // cleared flag shows the idle level
    srShown = regRst_b && srActive_d;
    srPin_d = (mode_q == MODE_OUTPUT) ? srShown : !srShown;
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      outEn_q <= 1'b0;
      srPin_q <= 1'b1;
    end else begin
      outEn_q <= outEn_d;
      srPin_q <= srPin_d;
    end
  end

  assign data_out_bus = latch_q;
  assign dataOutEnable = outEn_q;
  assign service_request = srPin_q;

  // each byte still loading when strobe falls is offered downstream; a full buffer drops it,
  // which captureRoom lets the receiver side see in advance
  logic pushValid;
  assign pushValid = strobeFall && loadPrev_q;

  capture_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_capture (
    .clk(clk),
    .rst_b(regRst_b),
    .inValid(pushValid),
    .inData(latch_q),
    .inReady(captureRoom),
    .outValid(captureValid),
    .outData(captureData),
    .outReady(captureReady)
  );

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!regRst_b);

  sequence sWriteEnd;
    mode_q == MODE_OUTPUT && selFall;
  endsequence

  sequence sNextFall;
    mode_q == MODE_OUTPUT && strobeFall && !selFall;
  endsequence

  sequence sInputFall;
    mode_q == MODE_INPUT && strobeFall && !sel;
  endsequence

  sequence sInputEnd;
    mode_q == MODE_INPUT && selFall && !strobeFall;
  endsequence

  chk_mode_fixed: assert property (
    modeLock_q |=> $stable(mode_q))
    else $error("mode changed while running");

  chk_follow_data: assert property (
    load |=> latch_q == $past(data_in_bus))
    else $error("buffer did not follow data");

  chk_hold_latch: assert property (
    !load |=> $stable(latch_q))
    else $error("buffer changed without strobe");

  chk_input_drive: assert property (
    mode_q == MODE_INPUT |=> dataOutEnable == $past(sel))
    else $error("input mode driver wrong");

  chk_output_drive: assert property (
    mode_q == MODE_OUTPUT ##1 mode_q == MODE_OUTPUT |-> dataOutEnable)
    else $error("output mode driver off");

  chk_write_gate: assert property (
    mode_q == MODE_OUTPUT && !(strobe && !selectFirst && selectSecond)
    |=> $stable(latch_q))
    else $error("write without full select");

  chk_clear_zero: assert property (
    @(posedge clk) disable iff (!rstSync_b)
    !clrSync_b |-> latch_q == LATCH_RST && !srActive_q)
    else $error("clear left state behind");

  chk_input_request: assert property (
    sInputFall |=> !service_request)
    else $error("input request not raised");

  chk_input_release: assert property (
    sInputEnd |=> service_request)
    else $error("input request not released");

  chk_request_hold: assert property (
    mode_q == MODE_INPUT && !strobeFall && !selFall
    |=> $stable(service_request))
    else $error("input request moved without event");

  chk_output_request: assert property (
    sWriteEnd |=> service_request ##0 srActive_q)
    else $error("output request not raised");

  chk_output_return: assert property (
    sNextFall |=> !service_request)
    else $error("output request not returned");

  chk_edge_detect: assert property (
    strobeFall == $fell(strobe))
    else $error("strobe fall misdetected");

  chk_output_keep: assert property (
    mode_q == MODE_OUTPUT ##1
    mode_q == MODE_OUTPUT && !selFall && !strobeFall
    |=> $stable(service_request))
    else $error("output request moved without event");

  chk_output_load: assert property (
    mode_q == MODE_OUTPUT && strobe && !selectFirst && selectSecond
    |=> latch_q == $past(data_in_bus))
    else $error("selected write did not load");

  chk_clear_pin: assert property (
    @(posedge clk) disable iff (!rstSync_b)
    !clrSync_b && modeLock_q |=> service_request == (mode_q == MODE_INPUT))
    else $error("request pin not idle under clear");

  chk_drive_clear: assert property (
    @(posedge clk) disable iff (!rstSync_b)
    mode_q == MODE_OUTPUT && modeLock_q |=> dataOutEnable)
    else $error("output driver dropped");

endmodule // byte_io_port_latch

// file: src/byte_io_pkg.sv
// shared constants and types of the byte port latch
// assumes a single system clock; no software-visible registers
package byte_io_pkg;

  localparam int DATA_W = 8;
  localparam int BUF_DEPTH = 2;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic SR_ACTIVE_RST = 1'b0;
  localparam logic SYNC_RST = 1'b0;

  typedef enum logic [0:0] {
    MODE_INPUT = 1'b0,
    MODE_OUTPUT = 1'b1
  } port_mode_t;

endpackage

// file: src/reset_release_sync.sv
// two-stage release synchroniser for an active-low asynchronous reset
// assumes the output feeds asynchronous resets in the clk domain
`timescale 1ns/1ps
module reset_release_sync
  import byte_io_pkg::*;
(
  input wire logic clk,
  input wire logic async_b,
  output logic sync_b
);
  logic stage_q;

  // assertion is immediate, release waits two edges
  always_ff @(posedge clk or negedge async_b) begin
    if (!async_b) begin
      stage_q <= SYNC_RST;
      sync_b <= SYNC_RST;
    end else begin
      stage_q <= 1'b1;
      sync_b <= stage_q;
    end
  end
endmodule // reset_release_sync

// file: src/capture_fifo.sv
// small shift-register fifo with valid and ready on both sides
// head entry and flags are flops so outputs need no extra stage
`timescale 1ns/1ps
module capture_fifo
  import byte_io_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int CW = $clog2(DEPTH + 1);

  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("capture_fifo needs DEPTH >= 2 and WIDTH >= 1");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [CW-1:0] count_q, count_d;
  logic readyQ, readyD, validQ, validD;
  logic push, pop;

  assign push = inValid && readyQ;
  assign pop = validQ && outReady;
  assign inReady = readyQ;
  assign outValid = validQ;
  assign outData = mem_q[0];

  always_comb begin
    logic [CW-1:0] slot;
    slot = count_q - CW'(pop);
    for (int i = 0; i < DEPTH; i++) begin
      if (pop && i < DEPTH - 1) begin
        mem_d[i] = mem_q[i + 1];
      end else begin
        mem_d[i] = mem_q[i];
      end
      if (push && slot == CW'(i)) begin
        mem_d[i] = inData;
      end
    end
    count_d = count_q + CW'(push) - CW'(pop);
    validD = count_d != '0;
    readyD = count_d != CW'(DEPTH);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      count_q <= '0;
      validQ <= 1'b0;
      readyQ <= 1'b0;
    end else begin
      mem_q <= mem_d;
      count_q <= count_d;
      validQ <= validD;
      readyQ <= readyD;
    end
  end
endmodule // capture_fifo

// file: tb/capture_sink.sv
// receiver model for the capture stream of the port latch
// assumes the bench drives stall after a rising edge
`timescale 1ns/1ps
module capture_sink (
  input wire logic clk,
  input wire logic stall,
  input wire logic captureValid,
  input wire logic [7:0] captureData,
  output logic captureReady
);
  logic [7:0] rx[$];

  // a stalled receiver stays ready low so the fifo must hold its words
  assign captureReady = !stall;

  always @(posedge clk) begin
    if (captureValid === 1'b1 && captureReady) begin
      rx.push_back(captureData);
    end
  end
endmodule // capture_sink

// file: tb/byte_io_port_latch_bench.sv
// self-checking bench of the byte port latch, both modes
// assumes the capture sink model beside the design
`timescale 1ns/1ps
module byte_io_port_latch_bench;
  import byte_io_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clear_b = 1'b1;
  logic modeSelect = 1'b0;
  logic strobe = 1'b0;
  logic selectFirst = 1'b0;
  logic selectSecond = 1'b0;
  logic [7:0] data_in_bus = 8'h00;
  logic [7:0] data_out_bus;
  logic dataOutEnable;
  logic service_request;
  logic captureValid;
  logic [7:0] captureData;
  logic captureReady;
  logic captureRoom;
  logic stall = 1'b0;
  int fails = 0;
  int checks = 0;

  always #50 clk = ~clk;

  byte_io_port_latch u_byte_io_port_latch (
    .clk(clk), .rst_b(rst_b), .clear_b(clear_b),
    .modeSelect(modeSelect), .strobe(strobe),
    .selectFirst(selectFirst), .selectSecond(selectSecond),
    .data_in_bus(data_in_bus), .data_out_bus(data_out_bus),
    .dataOutEnable(dataOutEnable), .service_request(service_request),
    .captureValid(captureValid), .captureData(captureData),
    .captureReady(captureReady), .captureRoom(captureRoom)
  );

  capture_sink u_capture_sink (
    .clk(clk), .stall(stall), .captureValid(captureValid),
    .captureData(captureData), .captureReady(captureReady)
  );

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic doReset(input logic mode);
    @(posedge clk);
    rst_b <= 1'b0;
    modeSelect <= mode;
    // park the port so no stale select or strobe survives the reset
    strobe <= 1'b0;
    selectFirst <= 1'b0;
    selectSecond <= 1'b0;
    data_in_bus <= 8'h00;
    step(6);
    @(posedge clk);
    rst_b <= 1'b1;
    step(4);
  endtask

  task automatic strobeByte(input logic [7:0] v);
    @(posedge clk);
    strobe <= 1'b1;
    data_in_bus <= v;
    step(2);
    @(posedge clk);
    strobe <= 1'b0;
    // data moves away with the fall; the latch must not follow
    data_in_bus <= ~v;
    step(3);
  endtask

  task automatic tInput();
    strobeByte(8'hA5);
    chk(data_out_bus, 8'hA5);
    chk({7'h00, service_request}, 8'h00);
    chk({7'h00, dataOutEnable}, 8'h00);
    chk(u_capture_sink.rx[0], 8'hA5);
    @(posedge clk);
    selectFirst <= 1'b1;
    selectSecond <= 1'b1;
    step(3);
    chk({7'h00, dataOutEnable}, 8'h01);
    @(posedge clk);
    selectSecond <= 1'b0;
    step(3);
    chk({7'h00, service_request}, 8'h01);
    chk({7'h00, dataOutEnable}, 8'h00);
  endtask

  task automatic tBuffer();
    int n0;
    n0 = u_capture_sink.rx.size();
    @(posedge clk);
    selectFirst <= 1'b0;
    stall <= 1'b1;
    strobeByte(8'h11);
    strobeByte(8'h22);
    strobeByte(8'h33);
    chk({7'h00, captureRoom}, 8'h00);
    chk(captureData, 8'h11);
    @(posedge clk);
    stall <= 1'b0;
    step(5);
    chk(u_capture_sink.rx.size() - n0, 8'h02);
    chk(u_capture_sink.rx[n0 + 1], 8'h22);
    chk({7'h00, captureValid}, 8'h00);
  endtask

  task automatic tClearPlain();
    strobeByte(8'h5A);
    @(posedge clk);
    clear_b <= 1'b0;
    step(2);
    chk(data_out_bus, 8'h00);
    chk({7'h00, service_request}, 8'h01);
    @(posedge clk);
    clear_b <= 1'b1;
    strobe <= 1'b1;
    selectSecond <= 1'b1;
    selectFirst <= 1'b1;
    data_in_bus <= 8'h3C;
    step(4);
    chk(data_out_bus, 8'h3C);
    chk({7'h00, dataOutEnable}, 8'h01);
    @(posedge clk);
    data_in_bus <= 8'hC3;
    selectFirst <= 1'b0;
    step(3);
    chk(data_out_bus, 8'hC3);
    chk({7'h00, dataOutEnable}, 8'h00);
  endtask

  task automatic tOutput();
    @(posedge clk);
    strobe <= 1'b1;
    selectFirst <= 1'b1;
    selectSecond <= 1'b1;
    data_in_bus <= 8'h77;
    step(3);
    @(posedge clk);
    strobe <= 1'b0;
    modeSelect <= 1'b0;
    step(3);
    chk(data_out_bus, 8'h00);
    chk({7'h00, dataOutEnable}, 8'h01);
    chk({7'h00, service_request}, 8'h00);
    @(posedge clk);
    selectFirst <= 1'b0;
    strobe <= 1'b1;
    data_in_bus <= 8'h96;
    step(3);
    chk(data_out_bus, 8'h96);
    @(posedge clk);
    strobe <= 1'b0;
    step(2);
    @(posedge clk);
    selectFirst <= 1'b1;
    data_in_bus <= 8'h69;
    step(3);
    chk({7'h00, service_request}, 8'h01);
    @(posedge clk);
    strobe <= 1'b1;
    step(2);
    @(posedge clk);
    strobe <= 1'b0;
    step(3);
    chk({7'h00, service_request}, 8'h00);
    chk(data_out_bus, 8'h96);
    @(posedge clk);
    clear_b <= 1'b0;
    step(2);
    chk(data_out_bus, 8'h00);
    chk({7'h00, dataOutEnable}, 8'h01);
    chk({7'h00, service_request}, 8'h00);
    @(posedge clk);
    clear_b <= 1'b1;
    step(3);
  endtask

  task automatic summarize();
    if (fails == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // the whole sequence needs well under 400 cycles
  initial begin
    #(3000 * 100);
    fails++;
    summarize();
  end

  initial begin
    doReset(1'b0);
    tInput();
    tBuffer();
    tClearPlain();
    doReset(1'b1);
    tOutput();
    summarize();
  end
endmodule // byte_io_port_latch_bench
